/* File: verilog/sp_select_pkg.sv */
// Shared constants and carriers for the stack pointer select register set
package sp_select_pkg;
  localparam int ADDR_W  = 32;
  localparam int SW_W    = 16;
  localparam int FLAG_W  = 8;
  // Status word bit positions
  localparam int BIT_C   = 0;
  localparam int BIT_V   = 1;
  localparam int BIT_Z   = 2;
  localparam int BIT_N   = 3;
  localparam int BIT_X   = 4;
  localparam int BIT_M   = 12;
  localparam int BIT_S   = 13;
  localparam logic [SW_W-1:0]   SW_RESET   = 16'h2700;
  localparam logic [ADDR_W-1:0] PTR_RESET  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] PC_RESET   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] INSN_STEP  = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] LONG_SIZE  = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] WORD_SIZE  = 32'h0000_0002;

  typedef enum logic [2:0] {
    CR_USP = 3'h0,
    CR_ISP = 3'h1,
    CR_MSP = 3'h2,
    CR_SW  = 3'h3,
    CR_VBR = 3'h4,
    CR_SFC = 3'h5,
    CR_DFC = 3'h6,
    CR_CF  = 3'h7
  } ctrl_reg_e;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_STEP   = 3'h1,
    OP_JUMP   = 3'h2,
    OP_CALL   = 3'h3,
    OP_RETURN = 3'h4,
    OP_EXCEPT = 3'h5
  } pc_op_e;

  typedef struct packed {
    logic            wr;
    ctrl_reg_e       sel;
    logic [ADDR_W-1:0] data;
  } ctrl_wr_s;

  typedef struct packed {
    logic        wr;
    logic [3:0]  nzvc;
    logic        x_wr;
    logic        x;
  } flag_upd_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] data;
    logic              wr;
    logic              valid;
  } stack_req_s;
endpackage : sp_select_pkg

/* File: verilog/flag_unit.sv */
// Condition flag byte: four result flags and a separate extend flag
`timescale 1ns/1ns
module flag_unit
  import sp_select_pkg::*;
(
  input  wire logic                   sys_clk,   // Processor clock
  input  wire logic                   sys_rst,   // Async reset, high
  input  wire sp_select_pkg::flag_upd_s upd,     // Update from execute
  input  wire logic                   load,      // Whole byte load
  input  wire logic [FLAG_W-1:0]      load_val,  // Byte to load
  output logic [FLAG_W-1:0]           flags      // Current flag byte
);
  import sp_select_pkg::*;

  logic [3:0] result_flags;
  logic       extend_flag;

  // Carry and extend live apart so a compare can leave X intact
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_flags <= 4'h0;
    end else if (load) begin
      result_flags <= load_val[BIT_N:BIT_C];
    end else if (upd.wr) begin
      result_flags <= upd.nzvc;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extend_flag <= 1'b0;
    end else if (load) begin
      extend_flag <= load_val[BIT_X];
    end else if (upd.x_wr) begin
      extend_flag <= upd.x;
    end
  end

  assign flags = {3'h0, extend_flag, result_flags};

  AST_X_INDEPENDENT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (upd.wr && !upd.x_wr && !load) |=> flags[BIT_X] == $past(flags[BIT_X]))
    else $error("extend flag moved on a result-only update");
endmodule : flag_unit

/* File: verilog/sp_select_regs.sv */
// Programming-model register set with stack pointer selection
//
// Notes on behaviour
// - One stack designation maps to user, interrupt and master pointers.
// - With supervisor bit clear the user pointer is active.
// - In user mode, system stack references resolve to the user pointer.
// - Call pushes instruction pointer on active stack; return pops it.
// - Exceptions save pointer and status on a supervisor stack, never user.
// - Instruction pointer holds address of the executing instruction.
// - Instruction pointer advances or loads a new value as operations need.
// - Instruction pointer serves as base for relative addressing.
// - Low four flag bits record the result conditions.
// - Fifth flag bit is the extend operand for multiprecision arithmetic.
// - Carry and extend are separate, independently updated bits.
// - Control features change only through supervisor registers.
// - Interrupt and master pointers are separate 32-bit registers.
// - Status word is 16 bits and contains the flag byte.
// - A supervisor-only 32-bit register holds the vector table base.
// - Two supervisor 32-bit registers hold source and destination space codes.
// - In supervisor mode master bit picks interrupt (0) or master (1).
// - After reset the interrupt pointer is the supervisor pointer.
// - Interrupt exceptions save then clear the master bit.
// - User-visible flag byte is 8 bits, low byte of status word.
`timescale 1ns/1ns
module sp_select_regs
  import sp_select_pkg::*;
(
  input  wire logic                      sys_clk,       // 10 MHz processor clock
  input  wire logic                      sys_rst,       // Async reset, high
  input  wire sp_select_pkg::pc_op_e     pc_op,         // Instruction pointer operation
  input  wire logic [ADDR_W-1:0]         pc_target,     // Jump, call or vector target
  input  wire logic [ADDR_W-1:0]         pop_data,      // Word popped on return
  input  wire logic                      exc_is_irq,    // Exception is an interrupt
  input  wire logic [ADDR_W-1:0]         rel_disp,      // Relative displacement
  input  wire sp_select_pkg::ctrl_wr_s   ctrl_wr,       // Control register write
  input  wire sp_select_pkg::flag_upd_s  flag_upd,      // Flag update from execute
  input  wire logic                      sp_wr,         // Write active stack designation
  input  wire logic [ADDR_W-1:0]         sp_wdata,      // Data for active stack
  output sp_select_pkg::stack_req_s      stack_req,     // Stack memory request
  output logic [ADDR_W-1:0]              active_sp,     // Active stack designation
  output logic [ADDR_W-1:0]              instruction_pointer, // Executing address
  output logic [ADDR_W-1:0]              rel_addr,      // Relative effective address
  output logic [SW_W-1:0]                status_word,   // Full status word
  output logic [ADDR_W-1:0]              vector_table_base, // Vector table base
  output logic [ADDR_W-1:0]              source_space_code, // Source space code
  output logic [ADDR_W-1:0]              dest_space_code,   // Destination space code
  output logic                           priv_violation // Privilege violation pulse
);
  import sp_select_pkg::*;

  typedef enum logic [1:0] {
    SEL_USER = 2'b00,
    SEL_INTR = 2'b01,
    SEL_MSTR = 2'b10
  } sp_sel_e;

  function automatic sp_sel_e pick_sp(input logic s_bit, input logic m_bit);
    if (!s_bit) begin
      return SEL_USER;
    end
    return m_bit ? SEL_MSTR : SEL_INTR;
  endfunction : pick_sp

  logic [ADDR_W-1:0] user_stack_ptr;
  logic [ADDR_W-1:0] interrupt_stack_ptr;
  logic [ADDR_W-1:0] master_stack_ptr;
  logic [SW_W-1:0]   sw_upper;
  logic [FLAG_W-1:0] condition_flags;
  logic [1:0]        exc_phase;

  wire logic       s_bit     = sw_upper[BIT_S];
  wire logic       m_bit     = sw_upper[BIT_M];
  wire sp_sel_e    cur_sel   = pick_sp(s_bit, m_bit);
  wire logic       is_exc    = (pc_op == OP_EXCEPT);
  wire logic       is_call   = (pc_op == OP_CALL);
  wire logic       is_ret    = (pc_op == OP_RETURN);
  // Exception stacking always goes to a supervisor pointer, chosen after the M update
  wire logic       exc_m     = exc_is_irq ? 1'b0 : m_bit;
  wire sp_sel_e    exc_sel   = pick_sp(1'b1, exc_m);
  wire logic [ADDR_W-1:0] cur_sp =
    (cur_sel == SEL_USER) ? user_stack_ptr :
    (cur_sel == SEL_MSTR) ? master_stack_ptr : interrupt_stack_ptr;
  wire logic [ADDR_W-1:0] exc_sp = exc_m ? master_stack_ptr : interrupt_stack_ptr;
  wire logic       ctrl_ok   = ctrl_wr.wr && s_bit;
  wire logic       ctrl_bad  = ctrl_wr.wr && !s_bit && (ctrl_wr.sel != CR_CF);
  wire logic       cf_write  = ctrl_wr.wr && (ctrl_wr.sel == CR_CF);
  wire logic       sw_write  = ctrl_ok && (ctrl_wr.sel == CR_SW);
  wire logic       flag_load = cf_write || sw_write;

  // Stack pointer arithmetic for each kind of access
  wire logic [ADDR_W-1:0] push_addr = cur_sp - LONG_SIZE;
  wire logic [ADDR_W-1:0] pop_next  = cur_sp + LONG_SIZE;
  wire logic [ADDR_W-1:0] exc_pc_at = exc_sp - LONG_SIZE;
  wire logic [ADDR_W-1:0] exc_sw_at = exc_sp - LONG_SIZE - WORD_SIZE;

  flag_unit u_flags (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .upd      (flag_upd),
    .load     (flag_load),
    .load_val (ctrl_wr.data[FLAG_W-1:0]),
    .flags    (condition_flags)
  );

  // User pointer: touched by stacking only while in user mode
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      user_stack_ptr <= PTR_RESET;
    end else if (ctrl_ok && ctrl_wr.sel == CR_USP) begin
      user_stack_ptr <= ctrl_wr.data;
    end else if (cur_sel == SEL_USER && !is_exc) begin
      if (is_call) begin
        user_stack_ptr <= push_addr;
      end else if (is_ret) begin
        user_stack_ptr <= pop_next;
      end else if (sp_wr) begin
        user_stack_ptr <= sp_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_stack_ptr <= PTR_RESET;
    end else if (is_exc && !exc_m) begin
      interrupt_stack_ptr <= exc_sw_at;
    end else if (ctrl_ok && ctrl_wr.sel == CR_ISP) begin
      interrupt_stack_ptr <= ctrl_wr.data;
    end else if (cur_sel == SEL_INTR && !is_exc) begin
      if (is_call) begin
        interrupt_stack_ptr <= push_addr;
      end else if (is_ret) begin
        interrupt_stack_ptr <= pop_next;
      end else if (sp_wr) begin
        interrupt_stack_ptr <= sp_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      master_stack_ptr <= PTR_RESET;
    end else if (is_exc && exc_m) begin
      master_stack_ptr <= exc_sw_at;
    end else if (ctrl_ok && ctrl_wr.sel == CR_MSP) begin
      master_stack_ptr <= ctrl_wr.data;
    end else if (cur_sel == SEL_MSTR && !is_exc) begin
      if (is_call) begin
        master_stack_ptr <= push_addr;
      end else if (is_ret) begin
        master_stack_ptr <= pop_next;
      end else if (sp_wr) begin
        master_stack_ptr <= sp_wdata;
      end
    end
  end

  // Upper status byte; reset leaves S set and M clear so the interrupt pointer is live
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_upper <= SW_RESET;
    end else if (is_exc) begin
      sw_upper[BIT_S] <= 1'b1;
      sw_upper[BIT_M] <= exc_m;
    end else if (sw_write) begin
      sw_upper <= {ctrl_wr.data[SW_W-1:FLAG_W], {FLAG_W{1'b0}}};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vector_table_base <= PTR_RESET;
      source_space_code <= PTR_RESET;
      dest_space_code   <= PTR_RESET;
    end else if (ctrl_ok) begin
      if (ctrl_wr.sel == CR_VBR) vector_table_base <= ctrl_wr.data;
      if (ctrl_wr.sel == CR_SFC) source_space_code <= ctrl_wr.data;
      if (ctrl_wr.sel == CR_DFC) dest_space_code   <= ctrl_wr.data;
    end
  end

  // Instruction pointer; exceptions take two cycles to push pointer then status
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      instruction_pointer <= PC_RESET;
    end else begin
      unique case (pc_op)
        OP_NONE:   instruction_pointer <= instruction_pointer;
        OP_STEP:   instruction_pointer <= instruction_pointer + INSN_STEP;
        OP_JUMP:   instruction_pointer <= pc_target;
        OP_CALL:   instruction_pointer <= pc_target;
        OP_RETURN: instruction_pointer <= pop_data;
        OP_EXCEPT: instruction_pointer <= pc_target;
        default:   instruction_pointer <= instruction_pointer;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_req <= '0;
    end else if (is_exc) begin
      stack_req <= '{addr: exc_pc_at, data: instruction_pointer, wr: 1'b1, valid: 1'b1};
    end else if (is_call) begin
      stack_req <= '{addr: push_addr, data: instruction_pointer, wr: 1'b1, valid: 1'b1};
    end else if (is_ret) begin
      stack_req <= '{addr: cur_sp, data: PTR_RESET, wr: 1'b0, valid: 1'b1};
    end else if (exc_phase == 2'h1) begin
      stack_req <= '{addr: interrupt_or_master_sw(), data: {{(ADDR_W-SW_W){1'b0}}, status_word},
                     wr: 1'b1, valid: 1'b1};
    end else begin
      stack_req <= '0;
    end
  end

  function automatic logic [ADDR_W-1:0] interrupt_or_master_sw();
    return m_bit ? master_stack_ptr : interrupt_stack_ptr;
  endfunction : interrupt_or_master_sw

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exc_phase <= 2'h0;
    end else begin
      exc_phase <= is_exc ? 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_sp      <= PTR_RESET;
      status_word    <= SW_RESET;
      rel_addr       <= PC_RESET;
      priv_violation <= 1'b0;
    end else begin
      active_sp      <= cur_sp;
      status_word    <= {sw_upper[SW_W-1:FLAG_W], condition_flags};
      rel_addr       <= instruction_pointer + rel_disp;
      priv_violation <= ctrl_bad;
    end
  end

  AST_USER_SELECT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !s_bit |-> cur_sel == SEL_USER)
    else $error("user pointer not active with supervisor bit clear");
  AST_ACTIVE_OUT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !s_bit |=> active_sp == $past(user_stack_ptr))
    else $error("active pointer output is not the user pointer in user mode");
  AST_SUPER_SELECT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_bit |-> cur_sel == (m_bit ? SEL_MSTR : SEL_INTR))
    else $error("wrong supervisor pointer selected");
  AST_CALL_PUSH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_call |=> stack_req.valid && stack_req.wr && stack_req.data == $past(instruction_pointer)
               && instruction_pointer == $past(pc_target))
    else $error("call did not push instruction pointer");
  AST_EXC_NO_USER: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_exc |=> user_stack_ptr == $past(user_stack_ptr) ##1 stack_req.valid && stack_req.wr)
    else $error("exception touched user stack or skipped status push");
  AST_IRQ_CLEARS_M: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (is_exc && exc_is_irq) |=> !m_bit && s_bit)
    else $error("interrupt did not clear master bit");
  AST_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pc_op == OP_STEP |=> instruction_pointer == $past(instruction_pointer) + INSN_STEP)
    else $error("instruction pointer did not advance");
  AST_PRIV_BLOCK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctrl_bad |=> priv_violation && vector_table_base == $past(vector_table_base)
                 && sw_upper == $past(sw_upper))
    else $error("user-mode control write was not refused");
  // The release edge still loads reset values, so start checking one edge later
  AST_REL_ADDR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sys_rst |=> rel_addr == $past(instruction_pointer) + $past(rel_disp))
    else $error("relative address wrong");

  AST_RET_POP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_ret |=> instruction_pointer == $past(pop_data) && stack_req.valid && !stack_req.wr)
    else $error("return did not restore instruction pointer");

  AST_EXC_PC_FRAME: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_exc |=> stack_req.addr == $past(exc_sp) - LONG_SIZE && stack_req.data == $past(instruction_pointer))
    else $error("exception frame pointer slot wrong");

  AST_EXC_SW_FRAME: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_exc |=> ##1 stack_req.valid && stack_req.wr && stack_req.data[SW_W-1:0] == $past(status_word))
    else $error("exception frame status slot wrong");

  AST_MSP_EXC: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (is_exc && exc_m) |=> master_stack_ptr == $past(master_stack_ptr) - LONG_SIZE - WORD_SIZE)
    else $error("master pointer not lowered by exception frame");

  AST_JUMP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pc_op == OP_JUMP |=> instruction_pointer == $past(pc_target))
    else $error("jump did not load instruction pointer");

  AST_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pc_op == OP_NONE |=> instruction_pointer == $past(instruction_pointer))
    else $error("instruction pointer moved while idle");

  AST_SUPER_OUT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_bit && !sys_rst) |=> active_sp == $past(m_bit ? master_stack_ptr : interrupt_stack_ptr))
    else $error("active pointer output is not the chosen supervisor pointer");

  AST_STATUS_OUT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sys_rst |=> status_word == {$past(sw_upper[SW_W-1:FLAG_W]), $past(condition_flags)})
    else $error("status word does not hold the flag byte low");

  AST_VBR_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrl_ok && ctrl_wr.sel == CR_VBR) |=> vector_table_base == $past(ctrl_wr.data))
    else $error("vector table base write lost");

  AST_SFC_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrl_ok && ctrl_wr.sel == CR_SFC) |=> source_space_code == $past(ctrl_wr.data))
    else $error("source space code write lost");

  AST_RESET_INTR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!sys_rst && $past(sys_rst)) |-> cur_sel == SEL_INTR)
    else $error("interrupt pointer not selected after reset");

  AST_CF_FREE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ctrl_wr.wr && ctrl_wr.sel == CR_CF) |=> !priv_violation)
    else $error("flag byte write flagged as violation");

  COV_CALL_USER: cover property (@(posedge sys_clk) disable iff (sys_rst) is_call && !s_bit);
  COV_IRQ_FROM_MSTR: cover property (@(posedge sys_clk) disable iff (sys_rst) is_exc && exc_is_irq && m_bit);
  COV_PRIV_FAULT: cover property (@(posedge sys_clk) disable iff (sys_rst) ctrl_bad);
  COV_RET_SUPER: cover property (@(posedge sys_clk) disable iff (sys_rst) is_ret && s_bit);
  COV_EXC_MSTR: cover property (@(posedge sys_clk) disable iff (sys_rst) is_exc && !exc_is_irq && m_bit);
endmodule : sp_select_regs

/* File: sim/tb.sv */
// Self-checking testbench for the stack pointer select register set
`timescale 1ns/1ns
module tb;
  import sp_select_pkg::*;
  typedef struct {
    pc_op_e      op;
    logic [31:0] tgt, pop;
    logic        irq;
    ctrl_wr_s    cw;
    flag_upd_s   fu;
    logic        spw;
    logic [31:0] spd, e_ip, e_sp;
    logic [15:0] e_sw, e_ss;
    logic [31:0] e_pa, e_pd;
  } row_s;
  localparam ctrl_wr_s  NC = '0;
  localparam flag_upd_s NF = '0;
  logic        sys_clk, sys_rst, exc_is_irq, sp_wr, priv_violation, pv;
  pc_op_e      pc_op;
  logic [31:0] pc_target, pop_data, rel_disp, sp_wdata, active_sp, instruction_pointer, rel_addr;
  logic [31:0] vector_table_base, source_space_code, dest_space_code;
  logic [15:0] status_word;
  ctrl_wr_s    ctrl_wr;
  flag_upd_s   flag_upd;
  stack_req_s  stack_req, r1, r2;
  int          n_errors, samples_checked, cycles;
  row_s        rows [19];
  ctrl_reg_e   priv_sel [6] = '{CR_ISP, CR_MSP, CR_SW, CR_VBR, CR_SFC, CR_DFC};

  sp_select_regs dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pc_op(pc_op), .pc_target(pc_target), .pop_data(pop_data),
    .exc_is_irq(exc_is_irq), .rel_disp(rel_disp), .ctrl_wr(ctrl_wr), .flag_upd(flag_upd), .sp_wr(sp_wr),
    .sp_wdata(sp_wdata), .stack_req(stack_req), .active_sp(active_sp), .instruction_pointer(instruction_pointer),
    .rel_addr(rel_addr), .status_word(status_word), .vector_table_base(vector_table_base),
    .source_space_code(source_space_code), .dest_space_code(dest_space_code), .priv_violation(priv_violation)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic ctrl_wr_s cw(ctrl_reg_e s, logic [31:0] d);
    return '{1'b1, s, d};
  endfunction : cw

  function automatic row_s mk(pc_op_e op, logic [31:0] tgt, ctrl_wr_s c, flag_upd_s f, logic [31:0] ip,
                              logic [31:0] sp, logic [15:0] sw, logic [31:0] pa = 32'h0, logic [31:0] pd = 32'h0,
                              logic [15:0] ss = 16'h0, logic irq = 1'b0, logic [31:0] pop = 32'h0,
                              logic spw = 1'b0, logic [31:0] spd = 32'h0);
    row_s r;
    r = '{op, tgt, pop, irq, c, f, spw, spd, ip, sp, sw, ss, pa, pd};
    return r;
  endfunction : mk

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // One operation, then idle cycles so lagging outputs settle; pulses are caught on the way
  task automatic step(input row_s r);
    @(posedge sys_clk);
    pc_op <= r.op;
    pc_target <= r.tgt;
    pop_data <= r.pop;
    exc_is_irq <= r.irq;
    ctrl_wr <= r.cw;
    flag_upd <= r.fu;
    sp_wr <= r.spw;
    sp_wdata <= r.spd;
    @(posedge sys_clk);
    pc_op <= OP_NONE;
    ctrl_wr <= NC;
    flag_upd <= NF;
    sp_wr <= 1'b0;
    #1 r1 = stack_req;
    pv = priv_violation;
    @(posedge sys_clk);
    #1 r2 = stack_req;
    pv = pv | priv_violation;
    @(posedge sys_clk);
    #1 pv = pv | priv_violation;
  endtask : step

  task automatic wr_ctrl(ctrl_reg_e s, logic [31:0] d);
    step(mk(OP_NONE, 32'h0, cw(s, d), NF, 32'h0, 32'h0, 16'h0));
  endtask : wr_ctrl

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      close_out;
    end
  end

  initial begin
    sys_rst = 1'b1;
    pc_op = OP_NONE;
    pc_target = 32'h0;
    pop_data = 32'h0;
    exc_is_irq = 1'b0;
    rel_disp = 32'h10;
    ctrl_wr = NC;
    flag_upd = NF;
    sp_wr = 1'b0;
    sp_wdata = 32'h0;
    rows[0] = mk(OP_NONE, 32'h0, cw(CR_ISP, 32'h1000), NF, 32'h0, 32'h1000, 16'h2700);
    rows[1] = mk(OP_NONE, 32'h0, cw(CR_MSP, 32'h2000), NF, 32'h0, 32'h1000, 16'h2700);
    rows[2] = mk(OP_NONE, 32'h0, cw(CR_USP, 32'h3000), NF, 32'h0, 32'h1000, 16'h2700);
    rows[3] = mk(OP_STEP, 32'h0, NC, NF, 32'h2, 32'h1000, 16'h2700);
    rows[4] = mk(OP_CALL, 32'h100, NC, NF, 32'h100, 32'h0ffc, 16'h2700, 32'h0ffc, 32'h2);
    rows[5] = mk(OP_RETURN, 32'h0, NC, NF, 32'h40, 32'h1000, 16'h2700, .pop(32'h40));
    rows[6] = mk(OP_NONE, 32'h0, cw(CR_CF, 32'hff), NF, 32'h40, 32'h1000, 16'h271f);
    rows[7] = mk(OP_NONE, 32'h0, NC, '{1'b1, 4'h0, 1'b0, 1'b0}, 32'h40, 32'h1000, 16'h2710);
    rows[8] = mk(OP_NONE, 32'h0, NC, '{1'b0, 4'h0, 1'b1, 1'b0}, 32'h40, 32'h1000, 16'h2700);
    rows[9] = mk(OP_NONE, 32'h0, NC, '{1'b1, 4'ha, 1'b1, 1'b1}, 32'h40, 32'h1000, 16'h271a);
    rows[10] = mk(OP_NONE, 32'h0, cw(CR_SW, 32'h301a), NF, 32'h40, 32'h2000, 16'h301a);
    rows[11] = mk(OP_EXCEPT, 32'h200, NC, NF, 32'h200, 32'h0ffa, 16'h201a, 32'h0ffc, 32'h40, 16'h301a, 1'b1);
    rows[12] = mk(OP_NONE, 32'h0, cw(CR_SW, 32'h001a), NF, 32'h200, 32'h3000, 16'h001a);
    rows[13] = mk(OP_NONE, 32'h0, NC, NF, 32'h200, 32'h3100, 16'h001a, .spw(1'b1), .spd(32'h3100));
    rows[14] = mk(OP_CALL, 32'h300, NC, NF, 32'h300, 32'h30fc, 16'h001a, 32'h30fc, 32'h200);
    rows[15] = mk(OP_EXCEPT, 32'h400, NC, NF, 32'h400, 32'h0ff4, 16'h201a, 32'h0ff6, 32'h300, 16'h001a);
    rows[16] = mk(OP_NONE, 32'h0, cw(CR_SW, 32'h301a), NF, 32'h400, 32'h2000, 16'h301a);
    rows[17] = mk(OP_EXCEPT, 32'h500, NC, NF, 32'h500, 32'h1ffa, 16'h301a, 32'h1ffc, 32'h400, 16'h301a);
    rows[18] = mk(OP_NONE, 32'h0, cw(CR_SW, 32'h2700), NF, 32'h500, 32'h0ff4, 16'h2700);
    @(posedge sys_clk);
    #1 chk("reset sw", status_word, 32'h2700);
    chk("reset ip", instruction_pointer, 32'h0);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      step(rows[i]);
      chk("ip", instruction_pointer, rows[i].e_ip);
      chk("active sp", active_sp, rows[i].e_sp);
      chk("status", status_word, rows[i].e_sw);
      chk("rel addr", rel_addr, rows[i].e_ip + 32'h10);
      chk("no violation", pv, 32'h0);
      if (rows[i].e_pa !== 32'h0) begin
        chk("push addr", r1.addr, rows[i].e_pa);
        chk("push data", r1.data, rows[i].e_pd);
        chk("push kind", {r1.valid, r1.wr}, 32'h3);
      end
      if (rows[i].op == OP_EXCEPT) begin
        chk("status push addr", r2.addr, rows[i].e_sp);
        chk("status push data", r2.data[15:0], rows[i].e_ss);
      end
    end
    wr_ctrl(CR_VBR, 32'h8000);
    wr_ctrl(CR_SFC, 32'h5);
    wr_ctrl(CR_DFC, 32'h1);
    chk("vbr", vector_table_base, 32'h8000);
    chk("sfc", source_space_code, 32'h5);
    chk("dfc", dest_space_code, 32'h1);
    wr_ctrl(CR_SW, 32'h0000);
    // Every supervisor-only target except USP is tried from user mode; all must be dropped
    foreach (priv_sel[i]) begin
      wr_ctrl(priv_sel[i], 32'hffff);
      chk("refused write flagged", pv, 32'h1);
    end
    chk("vbr kept", vector_table_base, 32'h8000);
    chk("sfc kept", source_space_code, 32'h5);
    chk("dfc kept", dest_space_code, 32'h1);
    chk("user mode kept", status_word, 32'h0);
    chk("user sp", active_sp, 32'h30fc);
    wr_ctrl(CR_CF, 32'h05);
    chk("flag write allowed", pv, 32'h0);
    chk("flag byte", status_word, 32'h0005);
    @(posedge sys_clk);
    pc_op <= OP_CALL;
    pc_target <= 32'h600;
    @(posedge sys_clk);
    pc_target <= 32'h700;
    #1 r1 = stack_req;
    @(posedge sys_clk);
    pc_op <= OP_NONE;
    #1 r2 = stack_req;
    repeat (2) @(posedge sys_clk);
    #1 chk("b2b push1", r1.addr, 32'h30f8);
    chk("b2b data1", r1.data, 32'h500);
    chk("b2b push2", r2.addr, 32'h30f4);
    chk("b2b data2", r2.data, 32'h600);
    chk("b2b ip", instruction_pointer, 32'h700);
    chk("b2b sp", active_sp, 32'h30f4);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("rerun sw", status_word, 32'h2700);
    chk("rerun vbr", vector_table_base, 32'h0);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    wr_ctrl(CR_ISP, 32'h1234);
    chk("isp after reset", active_sp, 32'h1234);
    close_out;
  end
endmodule : tb
